// >>> hdl/wdg_pkg.sv
// Purpose: shared constants and types of the guard timer block
// Assumes: 8-bit register data in the low byte of a 32-bit bus word
// Notes: addresses are byte addresses on the register bus
package wdg_pkg;
  // oscillator and core clock rates
  localparam int unsigned OSC_HZ = 125000;
  localparam int unsigned CLK_HZ = 20000000;
  // core clock cycles per oscillator cycle
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  // shortest time-out in oscillator cycles
  localparam int unsigned BASE_OSC_CYCLES = 2048;
  // highest period code in use; higher codes are reserved
  localparam logic [3:0] PSEL_MAX = 4'h9;
  // unlock window in core clock cycles
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
  // register bus
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam logic [7:0] CTRL_ADDR = 8'h60;
  localparam logic [7:0] CAUSE_ADDR = 8'h64;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // guard_control_status fields
  localparam int CB_FLAG = 7;
  localparam int CB_IE = 6;
  localparam int CB_P3 = 5;
  localparam int CB_UNL = 4;
  localparam int CB_RE = 3;
  localparam int CB_PLO_HI = 2;
  // reset_cause_status fields
  localparam int SB_SCAN = 4;
  localparam int SB_WD = 3;
  localparam int SB_LOW = 2;
  localparam int SB_PIN = 1;
  localparam int SB_PWR = 0;
  localparam int CAUSE_W = 5;
  localparam logic [4:0] CAUSE_RESET = 5'h01;
  // operating modes, {reset enable, irq enable}
  typedef enum logic [1:0] {
    MODE_STOP = 2'b00,
    MODE_IRQ = 2'b01,
    MODE_RST = 2'b10,
    MODE_BOTH = 2'b11
  } wdg_mode_t;
endpackage

// >>> hdl/wdg_sync.sv
// Purpose: two-stage synchroniser for pins from outside the core clock
// Assumes: inputs are slow levels compared to the core clock
// Notes: only the second stage is visible outside
`timescale 1ns/10ps
module wdg_sync #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // first stage feeds second stage only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else if (ce) begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // wdg_sync

// >>> hdl/wdg_count.sv
// Purpose: time-out counter advanced by oscillator ticks
// Assumes: tick is a one-cycle pulse in the core clock domain
// Notes: a count at or beyond last expires on the next tick
`timescale 1ns/10ps
module wdg_count #(
  parameter int CNT_W = 20
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic tick,
  input wire logic clear,
  input wire logic run,
  input wire logic [CNT_W-1:0] last,
  output logic expire_q
);
  logic [CNT_W-1:0] cnt_q;

  // count ticks, expire with a one-cycle pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_q <= {CNT_W{1'b0}};
      expire_q <= 1'b0;
    end else if (ce) begin
      expire_q <= 1'b0;
      if (clear || !run) begin
        cnt_q <= {CNT_W{1'b0}};
      end else if (tick) begin
        // shorter period taking effect: expire at once
        if (cnt_q >= last) begin
          cnt_q <= {CNT_W{1'b0}};
          expire_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule // wdg_count

// >>> hdl/wdg_top.sv
// Purpose: guard timer with reset-cause flags behind an AXI4-Lite slave
// Assumes: sys_rst is the power-on reset of this block
// Notes: oscillator arrives as a pin and is sampled on clk
// How it works
// - counter advances on ticks of a separate 125 kHz oscillator
// - reaching the time-out gives interrupt or reset per mode
// - restart request returns counter to zero; software restarts in time
// - interrupt mode raises interrupt only; it can wake from sleep
// - reset mode gives a device reset instead of an interrupt
// - combined mode: first expiry interrupts, later expiry resets
// - always-on fuse forces reset enable one and irq enable zero
// - within four cycles a write without unlock sets enable and period
// - after a guard reset the timer stays enabled
// - scan reset sets bit 4; power-on or writing zero clears it
// - guard reset sets bit 3; power-on or writing zero clears it
// - low supply reset sets bit 2; power-on or writing zero clears
// - pin reset sets bit 1; power-on or writing zero clears it
// - power-on sets bit 0; only writing zero clears it
// - change-unlock clears itself four cycles after being written
// - guard reset flag holds reset enable at one until cleared
// - period codes select 2048 doubling to 1048576 cycles
// - guard reset leaves as a one-cycle pulse
`timescale 1ns/10ps
module wdg_top #(
  parameter int unsigned BASE_CYCLES = wdg_pkg::BASE_OSC_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic osc_clk,
  input wire logic guard_always_on_fuse,
  input wire logic pin_reset_evt,
  input wire logic low_supply_reset_evt,
  input wire logic scan_reset_evt,
  input wire logic restart_req,
  input wire logic irq_vector_ack,
  input wire logic [wdg_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [wdg_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wdg_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [wdg_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic guard_irq,
  output logic guard_sys_reset
);
  localparam int CNT_W = $clog2(BASE_CYCLES) + int'(wdg_pkg::PSEL_MAX);

  logic [4:0] pin_s;
  logic osc_prev_q;
  logic osc_tick;
  logic fuse;
  logic aw_held_q;
  logic w_held_q;
  logic [wdg_pkg::AXI_AW-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic wr_go;
  logic hit_ctrl;
  logic hit_cause;
  logic wr_ctrl;
  logic wr_cause;
  logic rd_take;
  logic ie_q;
  logic re_q;
  logic re_d;
  logic [3:0] psel_q;
  logic iflag_q;
  logic [2:0] unl_cnt_q;
  logic unl_open;
  logic unlock_wr;
  logic change_wr;
  logic [wdg_pkg::CAUSE_W-1:0] cause_q;
  logic [wdg_pkg::CAUSE_W-1:0] cause_set;
  logic re_eff;
  logic ie_eff;
  wdg_pkg::wdg_mode_t mode;
  logic expire;
  logic irq_set;
  logic rst_fire;
  logic [3:0] psel_eff;
  logic [CNT_W:0] span;
  logic [CNT_W:0] span_m1;
  logic [CNT_W-1:0] last;
  logic [7:0] ctrl_rd;

  ////////////////////////////////////////////////////////////////////
  // pin sampling

  // oscillator, fuse and reset-source levels
  wdg_sync #(
    .W(5)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .din({scan_reset_evt, low_supply_reset_evt, pin_reset_evt,
          guard_always_on_fuse, osc_clk}),
    .dout(pin_s)
  );

  // rising oscillator edge makes one tick
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_prev_q <= 1'b0;
    end else if (ce) begin
      osc_prev_q <= pin_s[0];
    end
  end
  assign osc_tick = pin_s[0] & ~osc_prev_q;
  assign fuse = pin_s[1];

  ////////////////////////////////////////////////////////////////////
  // register bus, write side

  assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
  assign hit_ctrl = awaddr_q[7:2] == wdg_pkg::CTRL_ADDR[7:2];
  assign hit_cause = awaddr_q[7:2] == wdg_pkg::CAUSE_ADDR[7:2];
  assign wr_ctrl = wr_go & hit_ctrl & wlane_q;
  assign wr_cause = wr_go & hit_cause & wlane_q;

  // address and data taken in either order, answer after both
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= {wdg_pkg::AXI_AW{1'b0}};
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= wdg_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= !(aw_held_q || (s_axi_awvalid && s_axi_awready) || wr_go)
                       && (!s_axi_bvalid || s_axi_bready);
      s_axi_wready <= !(w_held_q || (s_axi_wvalid && s_axi_wready) || wr_go)
                      && (!s_axi_bvalid || s_axi_bready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (hit_ctrl || hit_cause) ? wdg_pkg::RESP_OKAY
                                               : wdg_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register bus, read side

  assign rd_take = s_axi_arvalid & s_axi_arready;
  assign ctrl_rd = {iflag_q, ie_q, psel_q[3], unl_open, re_q, psel_q[2:0]};

  // one read at a time, data from a register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= {wdg_pkg::AXI_DW{1'b0}};
      s_axi_rresp <= wdg_pkg::RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= !rd_take && (!s_axi_rvalid || s_axi_rready);
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= wdg_pkg::RESP_OKAY;
        if (s_axi_araddr[7:2] == wdg_pkg::CTRL_ADDR[7:2]) begin
          s_axi_rdata <= {24'h000000, ctrl_rd};
        end else if (s_axi_araddr[7:2] == wdg_pkg::CAUSE_ADDR[7:2]) begin
          s_axi_rdata <= {27'h0, cause_q};
        end else begin
          s_axi_rdata <= {wdg_pkg::AXI_DW{1'b0}};
          s_axi_rresp <= wdg_pkg::RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // timed change sequence

  assign unl_open = unl_cnt_q != 3'h0;
  assign unlock_wr = wr_ctrl & wdata_q[wdg_pkg::CB_UNL] & wdata_q[wdg_pkg::CB_RE];
  assign change_wr = wr_ctrl & ~wdata_q[wdg_pkg::CB_UNL] & unl_open;

  // unlock window counts down and closes itself
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      unl_cnt_q <= 3'h0;
    end else if (ce) begin
      if (unlock_wr) begin
        unl_cnt_q <= wdg_pkg::UNLOCK_CYCLES;
      end else if (change_wr) begin
        unl_cnt_q <= 3'h0;
      end else if (unl_open) begin
        unl_cnt_q <= unl_cnt_q - 3'h1;
      end
    end
  end

  // next reset enable: locked, unlocked, forced
  always_comb begin
    re_d = re_q;
    if (change_wr) begin
      re_d = wdata_q[wdg_pkg::CB_RE];
    end else if (wr_ctrl && wdata_q[wdg_pkg::CB_RE]) begin
      re_d = 1'b1;
    end
    if (fuse || cause_q[wdg_pkg::SB_WD] || rst_fire) begin
      re_d = 1'b1;
    end
  end

  // reset enable and period code
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      re_q <= 1'b0;
      psel_q <= 4'h0;
    end else if (ce) begin
      re_q <= re_d;
      if (change_wr) begin
        psel_q <= {wdata_q[wdg_pkg::CB_P3], wdata_q[wdg_pkg::CB_PLO_HI:0]};
      end
    end
  end

  // irq enable, dropped by the vector in combined mode
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ie_q <= 1'b0;
    end else if (ce) begin
      if (fuse) begin
        ie_q <= 1'b0;
      end else if (wr_ctrl) begin
        ie_q <= wdata_q[wdg_pkg::CB_IE];
      end else if (irq_vector_ack && mode == wdg_pkg::MODE_BOTH) begin
        ie_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // time-out and actions

  assign re_eff = re_q | fuse;
  assign ie_eff = ie_q & ~fuse;
  assign mode = wdg_pkg::wdg_mode_t'({re_eff, ie_eff});

  // period code to last count, reserved codes as longest
  always_comb begin
    psel_eff = (psel_q > wdg_pkg::PSEL_MAX) ? wdg_pkg::PSEL_MAX : psel_q;
    span = (CNT_W + 1)'(BASE_CYCLES) << psel_eff;
    span_m1 = span - {{CNT_W{1'b0}}, 1'b1};
    last = span_m1[CNT_W-1:0];
  end

  // counter cleared by restart and by its own reset
  wdg_count #(
    .CNT_W(CNT_W)
  ) u_count (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .tick(osc_tick),
    .clear(restart_req | rst_fire),
    .run(mode != wdg_pkg::MODE_STOP),
    .last(last),
    .expire_q(expire)
  );

  // action on expiry per mode
  always_comb begin
    irq_set = 1'b0;
    rst_fire = 1'b0;
    if (expire) begin
      case (mode)
        wdg_pkg::MODE_STOP: begin
          irq_set = 1'b0;
        end
        wdg_pkg::MODE_IRQ: begin
          irq_set = 1'b1;
        end
        wdg_pkg::MODE_RST: begin
          rst_fire = 1'b1;
        end
        wdg_pkg::MODE_BOTH: begin
          if (iflag_q) begin
            rst_fire = 1'b1;
          end else begin
            irq_set = 1'b1;
          end
        end
        default: begin
          rst_fire = 1'b1;
        end
      endcase
    end
  end

  // sticky irq flag, set wins over clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      iflag_q <= 1'b0;
    end else if (ce) begin
      if (irq_set) begin
        iflag_q <= 1'b1;
      end else if (irq_vector_ack || (wr_ctrl && wdata_q[wdg_pkg::CB_FLAG])) begin
        iflag_q <= 1'b0;
      end
    end
  end

  // outputs, irq level and one-cycle reset pulse
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      guard_irq <= 1'b0;
      guard_sys_reset <= 1'b0;
    end else if (ce) begin
      guard_irq <= iflag_q & ie_eff;
      guard_sys_reset <= rst_fire;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // reset-cause flags

  assign cause_set = {pin_s[4], rst_fire, pin_s[3], pin_s[2], 1'b0};

  // each flag set by its source, cleared by writing zero
  for (genvar i = 0; i < wdg_pkg::CAUSE_W; i++) begin : g_cause
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        cause_q[i] <= wdg_pkg::CAUSE_RESET[i];
      end else if (ce) begin
        if (cause_set[i]) begin
          cause_q[i] <= 1'b1;
        end else if (wr_cause && !wdata_q[i]) begin
          cause_q[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_reset_one_cycle: assert property (
    guard_sys_reset |=> !guard_sys_reset)
    else $error("guard reset pulse longer than one cycle");
  chk_reset_sets_flag: assert property (
    guard_sys_reset |-> cause_q[wdg_pkg::SB_WD])
    else $error("guard reset without reset flag");
  chk_flag_holds_enable: assert property (
    cause_q[wdg_pkg::SB_WD] && $past(cause_q[wdg_pkg::SB_WD]) |-> re_q)
    else $error("reset enable low while reset flag set");
  chk_fuse_locks_mode: assert property (
    fuse && $past(fuse) && $past(ce) |-> re_q && !ie_q)
    else $error("fuse did not lock the mode bits");
  chk_unlock_self_clear: assert property (
    (unlock_wr && ce) ##1 (ce && !unlock_wr)[*4] |=> !unl_open)
    else $error("change unlock not cleared after four cycles");
  chk_period_locked: assert property (
    ce && $changed(psel_q) |-> $past(unl_open) && $past(wr_ctrl))
    else $error("period changed outside unlock window");
  chk_irq_mode_no_rst: assert property (
    expire && mode == wdg_pkg::MODE_IRQ && ce |=> iflag_q && !guard_sys_reset)
    else $error("interrupt mode expiry misbehaved");
  chk_rst_mode_resets: assert property (
    expire && mode == wdg_pkg::MODE_RST && ce |=> guard_sys_reset && !$rose(iflag_q))
    else $error("reset mode expiry gave no reset");
  chk_both_second_rst: assert property (
    expire && mode == wdg_pkg::MODE_BOTH && iflag_q && ce |=> guard_sys_reset)
    else $error("combined mode second expiry gave no reset");
  chk_restart_holds: assert property (
    restart_req && ce |=> !expire)
    else $error("expiry right after restart");
  chk_pin_sets_flag: assert property (
    pin_s[2] && ce |=> cause_q[wdg_pkg::SB_PIN])
    else $error("pin reset flag not set");
  chk_power_flag_kept: assert property (
    $fell(cause_q[wdg_pkg::SB_PWR]) |-> $past(wr_cause) && !$past(wdata_q[0]))
    else $error("power-on flag cleared without a write");
endmodule // wdg_top

// >>> testbench/wdg_top_bench.sv
// Purpose: self-checking bench of the guard timer and reset-cause flags
// Assumes: time-outs shortened by BASE_CYCLES; oscillator shortened likewise
// Notes: bus answers are awaited, never counted; bready and rready stay high
`timescale 1ns/10ps
module wdg_top_bench;
  localparam int BASE = 4;
  localparam int OSC_HALF = 403; // shortened oscillator, unrelated in phase to clk
  logic clk, sys_rst, ce, osc_clk, fuse, pin_evt, low_evt, scan_evt, restart_req, ack;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, resp;
  logic guard_irq, guard_sys_reset, prev_rst;
  logic [31:0] d;
  int err_total, check_count, rst_cnt, n0, expc, r;
  ////////////////////////////////////////////////////////////////////////////////
  wdg_top #(.BASE_CYCLES(BASE)) dut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .osc_clk(osc_clk), .guard_always_on_fuse(fuse), .pin_reset_evt(pin_evt),
    .low_supply_reset_evt(low_evt), .scan_reset_evt(scan_evt), .restart_req(restart_req),
    .irq_vector_ack(ack), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .guard_irq(guard_irq), .guard_sys_reset(guard_sys_reset));
  ////////////////////////////////////////////////////////////////////////////////
  // core clock and free-running oscillator
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    osc_clk = 1'b0;
    forever #OSC_HALF osc_clk = ~osc_clk;
  end
  // verdict and end of run
  task automatic stop_test;
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one aligned word write, answer awaited under a bound
  task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
    int n;
    logic ok;
    ok = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, v};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 60 && !ok; n++) begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        ok = 1'b1;
      end
    end
    if (!ok) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic ok;
    ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 60 && !ok; n++) begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        resp = rresp;
        ok = 1'b1;
      end
    end
    if (!ok) begin
      err_total++;
      stop_test();
    end
  endtask
  task automatic pulse_restart;
    restart_req <= 1'b1;
    @(posedge clk);
    restart_req <= 1'b0;
  endtask
  // waits for irq (sel 0) or reset pulse (sel 1) inside [lo, hi] cycles
  task automatic expect_evt(input int sel, input int lo, input int hi);
    int n;
    logic hit;
    hit = 1'b0;
    n = 0;
    while (!hit && n < hi) begin
      @(posedge clk);
      n++;
      hit = sel ? (guard_sys_reset === 1'b1) : (guard_irq === 1'b1);
    end
    check_count++;
    if (!hit || n < lo) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, n, lo);
    end
  endtask
  // model of the time-out in core cycles for a period code
  function automatic int tmo(input int c);
    return ((BASE << c) * 2 * OSC_HALF) / 50;
  endfunction
  function automatic logic [7:0] pb(input int c);
    return 8'((c & 8) << 2 | (c & 7));
  endfunction
  // reset pulse counter and width monitor
  always @(posedge clk) begin
    if (guard_sys_reset === 1'b1) begin
      rst_cnt++;
      if (prev_rst === 1'b1) chk(32'h2, 32'h1);
    end
    prev_rst = guard_sys_reset;
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {sys_rst, ce, bready, rready} = 4'hf;
    {fuse, pin_evt, low_evt, scan_evt, restart_req, ack} = 6'h00;
    {awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
    {err_total, check_count, rst_cnt, prev_rst} = '0;
    void'($urandom(77));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(wdg_pkg::CTRL_ADDR);
    chk(d, 32'h00);
    rd(wdg_pkg::CAUSE_ADDR);
    chk(d, 32'h01);
    rd(8'h68);
    chk(d, 32'h00);
    chk(resp, wdg_pkg::RESP_SLVERR);
    wr(8'h6c, 8'hff, 4'hf);
    chk(resp, wdg_pkg::RESP_SLVERR);
    // cause flags set by their sources, cleared by zero writes
    {pin_evt, low_evt, scan_evt} <= 3'h7;
    repeat (4) @(posedge clk);
    {pin_evt, low_evt, scan_evt} <= 3'h0;
    repeat (4) @(posedge clk);
    rd(wdg_pkg::CAUSE_ADDR);
    chk(d, 32'h17);
    r = $urandom & 32'h1f;
    wr(wdg_pkg::CAUSE_ADDR, 8'(r), 4'hf);
    expc = 32'h17 & r;
    rd(wdg_pkg::CAUSE_ADDR);
    chk(d, expc);
    wr(wdg_pkg::CAUSE_ADDR, 8'h00, 4'h0);
    rd(wdg_pkg::CAUSE_ADDR);
    chk(d, expc);
    {pin_evt, low_evt, scan_evt} <= 3'h7;
    repeat (4) @(posedge clk);
    {pin_evt, low_evt, scan_evt} <= 3'h0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    rd(wdg_pkg::CAUSE_ADDR);
    chk(d, 32'h01);
    wr(wdg_pkg::CAUSE_ADDR, 8'h00, 4'hf);
    rd(wdg_pkg::CAUSE_ADDR);
    chk(d, 32'h00);
    // clock enable low freezes pin sampling, pulse is missed
    ce <= 1'b0;
    pin_evt <= 1'b1;
    repeat (6) @(posedge clk);
    pin_evt <= 1'b0;
    repeat (2) @(posedge clk);
    ce <= 1'b1;
    repeat (4) @(posedge clk);
    rd(wdg_pkg::CAUSE_ADDR);
    chk(d, 32'h00);
    // interrupt mode over several period codes
    for (int c = 0; c < 3; c++) begin
      pulse_restart();
      wr(wdg_pkg::CTRL_ADDR, 8'h58, 4'hf);
      wr(wdg_pkg::CTRL_ADDR, 8'h40 | pb(c), 4'hf);
      rd(wdg_pkg::CTRL_ADDR);
      chk(d, 8'h40 | pb(c));
      pulse_restart();
      expect_evt(0, tmo(c) - 20, tmo(c) + 12);
      chk(rst_cnt, 0);
      rd(wdg_pkg::CTRL_ADDR);
      chk(d, 8'hc0 | pb(c));
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      repeat (2) @(posedge clk);
      chk(guard_irq, 1'b0);
    end
    // locked writes and the unlock window
    wr(wdg_pkg::CTRL_ADDR, 8'h00, 4'hf);
    rd(wdg_pkg::CTRL_ADDR);
    chk(d, 8'h02);
    wr(wdg_pkg::CTRL_ADDR, 8'h18, 4'hf);
    rd(wdg_pkg::CTRL_ADDR);
    chk(d & 32'h10, 32'h10);
    repeat (4) @(posedge clk);
    rd(wdg_pkg::CTRL_ADDR);
    chk(d & 32'h10, 32'h00);
    wr(wdg_pkg::CTRL_ADDR, 8'h00, 4'hf);
    rd(wdg_pkg::CTRL_ADDR);
    chk(d, 8'h0a);
    // reset mode with period code 2
    pulse_restart();
    expect_evt(1, tmo(2) - 20, tmo(2) + 12);
    chk(guard_irq, 1'b0);
    rd(wdg_pkg::CAUSE_ADDR);
    chk(d, 32'h08);
    pulse_restart();
    wr(wdg_pkg::CTRL_ADDR, 8'h18, 4'hf);
    wr(wdg_pkg::CTRL_ADDR, 8'h00, 4'hf);
    rd(wdg_pkg::CTRL_ADDR);
    chk(d & 32'h08, 32'h08);
    wr(wdg_pkg::CAUSE_ADDR, 8'h00, 4'hf);
    rd(wdg_pkg::CAUSE_ADDR);
    chk(d, 32'h00);
    wr(wdg_pkg::CTRL_ADDR, 8'h18, 4'hf);
    wr(wdg_pkg::CTRL_ADDR, 8'h00, 4'hf);
    rd(wdg_pkg::CTRL_ADDR);
    chk(d, 32'h00);
    // restarts in time hold the reset off
    wr(wdg_pkg::CTRL_ADDR, 8'h08, 4'hf);
    n0 = rst_cnt;
    repeat (8) begin
      pulse_restart();
      repeat ($urandom_range(10, 40)) @(posedge clk);
    end
    chk(rst_cnt, n0);
    expect_evt(1, 1, tmo(0) + 12);
    // combined mode: interrupt first, vector drops to reset mode
    wr(wdg_pkg::CAUSE_ADDR, 8'h00, 4'hf);
    wr(wdg_pkg::CTRL_ADDR, 8'h18, 4'hf);
    wr(wdg_pkg::CTRL_ADDR, 8'h48, 4'hf);
    pulse_restart();
    n0 = rst_cnt;
    expect_evt(0, tmo(0) - 20, tmo(0) + 12);
    chk(rst_cnt, n0);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    rd(wdg_pkg::CTRL_ADDR);
    chk(d, 32'h08);
    expect_evt(1, 1, 2 * tmo(0) + 30);
    // always-on fuse locks reset mode
    fuse <= 1'b1;
    repeat (4) @(posedge clk);
    wr(wdg_pkg::CTRL_ADDR, 8'h40, 4'hf);
    rd(wdg_pkg::CTRL_ADDR);
    chk(d & 32'h48, 32'h08);
    fuse <= 1'b0;
    stop_test();
  end
endmodule // wdg_top_bench
